// File: vsp_pkg.sv
`default_nettype none
package vsp_pkg;
   // timing
   localparam int         MCLK_PERIOD_NS = 8;
   localparam int         BCLK_PERIOD_NS = 160;
   localparam logic [3:0] BCLK_HALF_CYC  = 4'(BCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS));
   // widths and counts
   localparam int         SAMPLE_W   = 16;
   localparam int         SLOT_W     = 6;
   localparam int         IDX_W      = 4;
   localparam logic [4:0] SAMPLE_CNT = 5'h10;
   localparam logic [4:0] PULSE_SAT  = 5'h1F;
   localparam logic [2:0] LAST_BIT   = 3'h7;
   // serial_frame_config fields
   localparam int         FRM_EN_BIT      = 0;
   localparam int         FRM_DBL_BIT     = 1;
   localparam int         FRM_STROBED_BIT = 2;
   localparam int         FRM_SLOTS_LSB   = 8;
   // serial_channelN_config fields
   localparam int         CH_EN_BIT   = 0;
   localparam int         CH_DIR_BIT  = 1;
   localparam int         CH_LIN_BIT  = 2;
   localparam int         CH_LAW_BIT  = 3;
   localparam int         CH_SLOT_LSB = 4;
   localparam int         CH_IDX_LSB  = 12;
   // host controller apb map
   localparam logic [7:0] HA_CTRL   = 8'h00;
   localparam logic [7:0] HA_FRAME  = 8'h04;
   localparam logic [7:0] HA_TXPOS  = 8'h08;
   localparam logic [7:0] HA_RXPOS  = 8'h0C;
   localparam logic [7:0] HA_TXDATA = 8'h10;
   localparam logic [7:0] HA_RXDATA = 8'h14;
   localparam logic [7:0] HA_STATUS = 8'h18;
   localparam int         HC_EN_BIT      = 0;
   localparam int         HC_STROBED_BIT = 1;
   localparam int         HC_DBL_BIT     = 2;
   localparam int         HC_PULSES_LSB  = 4;
   localparam int         ST_DONE_BIT    = 0;
   localparam int         ST_FRAMES_LSB  = 8;
endpackage
`default_nettype wire

// File: vsp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vsp_link_if;
   logic frame_sync;
   logic bit_clock_in;
   logic rx_strobe;
   logic tx_strobe;
   logic dev_ds_o;
   logic dev_ds_oe;
   logic dev_us_o;
   logic dev_us_oe;
   logic host_ds_o;
   logic host_ds_oe;
   wire logic ds_level;
   wire logic us_level;

   // wired-and with pull-up: undriven lines read high
   assign ds_level = (dev_ds_oe ? dev_ds_o : 1'b1) & (host_ds_oe ? host_ds_o : 1'b1);
   assign us_level = dev_us_oe ? dev_us_o : 1'b1;

   modport dev (input frame_sync, bit_clock_in, rx_strobe, ds_level, us_level,
                output tx_strobe, dev_ds_o, dev_ds_oe, dev_us_o, dev_us_oe);
   modport host (input tx_strobe, us_level,
                 output frame_sync, bit_clock_in, rx_strobe, host_ds_o, host_ds_oe);
endinterface
`default_nettype wire

// File: vsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module vsp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         reset_n_i,
   // asynchronous in, filtered out
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } vsp_sync_state_t;

   vsp_sync_state_t s_r;
   vsp_sync_state_t s_nxt;

   always_comb begin
      s_nxt    = s_r;
      s_nxt.s1 = d_i;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      // a bit moves only once the last two stages agree
      s_nxt.q  = (s_r.s2 & s_r.s3) | (s_r.q & (s_r.s2 ^ s_r.s3));
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.q;
endmodule // vsp_sync
`default_nettype wire

// File: vsp_device.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - frame sync flags first clock of frame
// - frame is N slots of eight bits
// - single clock: launch rising, sample falling
// - double clock: launch first rising, sample second falling
// - two channels, coding and lines per channel
// - frame config: enable, clock mode, slot count
// - channel config: enable, slot, direction, coding, law
// - companded channel uses one slot, eight bits
// - linear channel: high byte, then low byte
// - linear channel needs even first slot
// - one mode at a time, data only
// - strobed mode: one word per frame
// - strobed mode: drive rising, capture falling
// - strobed transmit and receive run independently
// - transmit strobe sixteen clocks around the word
// - transmit line driven only under strobe
// - receive strobe lasts sixteen clocks
// - capture only the selected receive strobe pulse
// - receive strobe low at frame sync rise
module vsp_device (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             reset_n_i,
   // serial link
   vsp_link_if.dev               link,
   // configuration words
   input  wire logic [15:0]      serial_frame_config_i,
   input  wire logic [15:0]      serial_channel1_config_i,
   input  wire logic [15:0]      serial_channel2_config_i,
   // sample data
   input  wire logic [1:0][15:0] tx_sample_i,
   output logic      [1:0][15:0] rx_sample_o,
   output logic      [1:0]       rx_valid_o,
   output logic                  frame_start_o
);
   typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SEND} vsp_tx_state_t;

   typedef struct packed {
      logic            bclk_q;
      logic            fs_q;
      logic            rs_q;
      logic            aligned;
      logic [9:0]      cyc;
      logic [1:0][15:0] tx_hold;
      logic [1:0][15:0] rx_sh;
      logic [1:0][15:0] rx_data;
      logic [1:0]      rx_valid;
      logic            frame_start;
      logic            ds_o;
      logic            ds_oe;
      logic            us_o;
      logic            us_oe;
      logic            tx_strobe;
      vsp_tx_state_t   tx_st;
      logic [4:0]      tx_cnt;
      logic [15:0]     tx_sh;
      logic [4:0]      rs_cnt;
      logic [4:0]      rs_bits;
   } vsp_dev_state_t;

   vsp_dev_state_t   s_r;
   vsp_dev_state_t   s_nxt;
   logic [4:0]       sy_q;
   logic             clk_f;
   logic             fs_f;
   logic             rs_f;
   logic             ds_f;
   logic             us_f;
   logic [1:0][15:0] ch_cfg;
   logic             en;
   logic             dbl;
   logic             strobed;
   logic [9:0]       flen;
   logic             rise;
   logic             fall;
   logic             fs_new;
   logic [8:0]       bit_v;
   logic [1:0][1:0]  hit;
   logic             tx_bit;
   logic [4:0]       sidx_v;

   // which of its two slots a channel occupies in this slot
   function automatic logic [1:0] slot_match(input logic [15:0] cfg, input logic [5:0] slot);
      logic [5:0] first;
      first         = cfg[vsp_pkg::CH_SLOT_LSB +: vsp_pkg::SLOT_W];
      slot_match[0] = cfg[vsp_pkg::CH_EN_BIT] && (slot == first);
      slot_match[1] = cfg[vsp_pkg::CH_EN_BIT] && cfg[vsp_pkg::CH_LIN_BIT]
                      && (slot == 6'(first + 6'h01));
   endfunction

   vsp_sync #(
      .W (5)
   ) u_sync (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .d_i       ({link.bit_clock_in, link.frame_sync, link.rx_strobe,
                   link.ds_level, link.us_level}),
      .q_o       (sy_q)
   );

   assign {clk_f, fs_f, rs_f, ds_f, us_f} = sy_q;
   assign ch_cfg  = {serial_channel2_config_i, serial_channel1_config_i};
   assign en      = serial_frame_config_i[vsp_pkg::FRM_EN_BIT];
   assign strobed = serial_frame_config_i[vsp_pkg::FRM_STROBED_BIT];
   assign dbl     = serial_frame_config_i[vsp_pkg::FRM_DBL_BIT];
   // cycles per frame: slots times eight bits, doubled in double clock mode
   assign flen    = dbl ? {serial_frame_config_i[vsp_pkg::FRM_SLOTS_LSB +: vsp_pkg::SLOT_W], 4'h0}
                        : {1'b0, serial_frame_config_i[vsp_pkg::FRM_SLOTS_LSB +: vsp_pkg::SLOT_W],
                           3'h0};
   assign sidx_v  = 5'(serial_channel1_config_i[vsp_pkg::CH_IDX_LSB +: vsp_pkg::IDX_W]) + 5'h01;

   always_comb begin
      s_nxt             = s_r;
      bit_v             = '0;
      hit               = '0;
      tx_bit            = 1'b0;
      rise              = clk_f & ~s_r.bclk_q;
      fall              = ~clk_f & s_r.bclk_q;
      fs_new            = fall & fs_f & ~s_r.fs_q;
      s_nxt.bclk_q      = clk_f;
      s_nxt.rx_valid    = '0;
      s_nxt.frame_start = 1'b0;
      if (fall) begin
         s_nxt.fs_q = fs_f;
      end
      if (!en) begin
         s_nxt.aligned   = 1'b0;
         s_nxt.cyc       = '0;
         s_nxt.ds_oe     = 1'b0;
         s_nxt.us_oe     = 1'b0;
         s_nxt.tx_strobe = 1'b0;
         s_nxt.tx_st     = TX_IDLE;
         s_nxt.rs_cnt    = '0;
         s_nxt.rs_bits   = '0;
      end else if (!strobed) begin
         s_nxt.tx_strobe = 1'b0;
         if (fs_new) begin
            s_nxt.cyc         = '0;
            s_nxt.aligned     = 1'b1;
            s_nxt.frame_start = 1'b1;
         end
         // receive on falling edge, second clock of a bit in double mode
         if (fall && (fs_new || s_r.aligned) && (!dbl || s_nxt.cyc[0])) begin
            bit_v = dbl ? s_nxt.cyc[9:1] : s_nxt.cyc[8:0];
            for (int c = 0; c < 2; c++) begin
               hit[c] = slot_match(ch_cfg[c], bit_v[8:3]);
               if (|hit[c]) begin
                  s_nxt.rx_sh[c] = {s_r.rx_sh[c][14:0],
                                    ch_cfg[c][vsp_pkg::CH_DIR_BIT] ? us_f : ds_f};
                  if (bit_v[2:0] == vsp_pkg::LAST_BIT &&
                      (ch_cfg[c][vsp_pkg::CH_LIN_BIT] ? hit[c][1] : hit[c][0])) begin
                     s_nxt.rx_data[c]  = ch_cfg[c][vsp_pkg::CH_LIN_BIT] ? s_nxt.rx_sh[c]
                                         : {8'h00, s_nxt.rx_sh[c][7:0]};
                     s_nxt.rx_valid[c] = 1'b1;
                  end
               end
            end
         end
         // predicted count on rising edge; a late frame sync realigns it
         if (rise && s_r.aligned) begin
            s_nxt.cyc = (10'(s_r.cyc + 10'h001) == flen) ? '0 : 10'(s_r.cyc + 10'h001);
            if (s_nxt.cyc == '0) begin
               s_nxt.tx_hold = tx_sample_i;
            end
            if (!dbl || !s_nxt.cyc[0]) begin
               bit_v       = dbl ? s_nxt.cyc[9:1] : s_nxt.cyc[8:0];
               s_nxt.ds_oe = 1'b0;
               s_nxt.us_oe = 1'b0;
               s_nxt.ds_o  = 1'b0;
               s_nxt.us_o  = 1'b0;
               for (int c = 0; c < 2; c++) begin
                  hit[c] = slot_match(ch_cfg[c], bit_v[8:3]);
                  if (|hit[c]) begin
                     // high byte in first slot of a linear channel, else low byte
                     tx_bit = s_nxt.tx_hold[c][{hit[c][0] & ch_cfg[c][vsp_pkg::CH_LIN_BIT],
                                                ~bit_v[2:0]}];
                     // open drain: pull low for a zero only
                     if (ch_cfg[c][vsp_pkg::CH_DIR_BIT]) begin
                        s_nxt.ds_oe = ~tx_bit;
                     end else begin
                        s_nxt.us_oe = ~tx_bit;
                     end
                  end
               end
            end
         end
      end else begin
         s_nxt.aligned = 1'b0;
         s_nxt.ds_oe   = 1'b0;
         if (fall) begin
            if (fs_new) begin
               s_nxt.tx_st       = TX_ARMED;
               s_nxt.rs_cnt      = '0;
               s_nxt.frame_start = 1'b1;
            end
            s_nxt.rs_q = rs_f;
            if (rs_f && !s_r.rs_q) begin
               s_nxt.rs_bits = '0;
               if (s_nxt.rs_cnt != vsp_pkg::PULSE_SAT) begin
                  s_nxt.rs_cnt = s_nxt.rs_cnt + 5'h01;
               end
            end
            // only the selected pulse feeds the shifter
            if (rs_f && s_nxt.rs_cnt == sidx_v) begin
               s_nxt.rx_sh[0] = {s_r.rx_sh[0][14:0], ds_f};
               s_nxt.rs_bits  = s_nxt.rs_bits + 5'h01;
               if (s_nxt.rs_bits == vsp_pkg::SAMPLE_CNT) begin
                  s_nxt.rx_data[0]  = s_nxt.rx_sh[0];
                  s_nxt.rx_valid[0] = 1'b1;
                  s_nxt.rs_bits     = '0;
               end
            end
         end
         // transmitter has its own state; it never looks at the receiver
         if (rise) begin
            unique case (s_r.tx_st)
               TX_IDLE: begin
                  s_nxt.us_oe = 1'b0;
               end
               TX_ARMED: begin
                  s_nxt.tx_sh     = {tx_sample_i[0][14:0], 1'b0};
                  s_nxt.us_o      = tx_sample_i[0][15];
                  s_nxt.us_oe     = 1'b1;
                  s_nxt.tx_strobe = 1'b1;
                  s_nxt.tx_cnt    = 5'h01;
                  s_nxt.tx_st     = TX_SEND;
               end
               TX_SEND: begin
                  if (s_r.tx_cnt == vsp_pkg::SAMPLE_CNT) begin
                     s_nxt.tx_strobe = 1'b0;
                     s_nxt.us_oe     = 1'b0;
                     s_nxt.us_o      = 1'b0;
                     s_nxt.tx_st     = TX_IDLE;
                  end else begin
                     s_nxt.us_o   = s_r.tx_sh[15];
                     s_nxt.tx_sh  = {s_r.tx_sh[14:0], 1'b0};
                     s_nxt.tx_cnt = s_r.tx_cnt + 5'h01;
                  end
               end
               default: begin
                  s_nxt.tx_st = TX_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rx_sample_o    = s_r.rx_data;
   assign rx_valid_o     = s_r.rx_valid;
   assign frame_start_o  = s_r.frame_start;
   assign link.tx_strobe = s_r.tx_strobe;
   assign link.dev_ds_o  = s_r.ds_o;
   assign link.dev_ds_oe = s_r.ds_oe;
   assign link.dev_us_o  = s_r.us_o;
   assign link.dev_us_oe = s_r.us_oe;
endmodule // vsp_device
`default_nettype wire

// File: vsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module vsp_host (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // serial link
   vsp_link_if.host         link
);
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic [7:0]  ctrl;
      logic [9:0]  frame;
      logic [9:0]  txpos;
      logic [9:0]  rxpos;
      logic [15:0] txdata;
      logic [15:0] rxdata;
      logic        rx_done;
      logic [7:0]  frames;
      logic [3:0]  hc;
      logic        bclk;
      logic        fs;
      logic        ds_o;
      logic        ds_oe;
      logic        strobe;
      logic [10:0] ccyc;
      logic [15:0] tx_sh;
      logic [15:0] rx_sh;
      logic [4:0]  tx_cnt;
      logic [4:0]  rx_cnt;
      logic [4:0]  pulses;
   } vsp_host_state_t;

   vsp_host_state_t s_r;
   vsp_host_state_t s_nxt;
   logic [1:0]      sy_q;
   logic            us_f;
   logic            txs_f;
   logic            en;
   logic            strobed;
   logic            dbl;
   logic [10:0]     clen;
   logic [9:0]      bp;
   logic            set_done;

   vsp_sync #(
      .W (2)
   ) u_sync (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .d_i       ({link.us_level, link.tx_strobe}),
      .q_o       (sy_q)
   );

   assign {us_f, txs_f} = sy_q;
   assign en      = s_r.ctrl[vsp_pkg::HC_EN_BIT];
   assign strobed = s_r.ctrl[vsp_pkg::HC_STROBED_BIT];
   assign dbl     = s_r.ctrl[vsp_pkg::HC_DBL_BIT] & ~strobed;
   assign clen    = dbl ? {s_r.frame, 1'b0} : {1'b0, s_r.frame};

   always_comb begin
      s_nxt        = s_r;
      bp           = '0;
      set_done     = 1'b0;
      s_nxt.pready = 1'b1;
      if (psel_i && !penable_i) begin
         unique case (paddr_i)
            vsp_pkg::HA_CTRL:   s_nxt.prdata = 32'(s_r.ctrl);
            vsp_pkg::HA_FRAME:  s_nxt.prdata = 32'(s_r.frame);
            vsp_pkg::HA_TXPOS:  s_nxt.prdata = 32'(s_r.txpos);
            vsp_pkg::HA_RXPOS:  s_nxt.prdata = 32'(s_r.rxpos);
            vsp_pkg::HA_TXDATA: s_nxt.prdata = 32'(s_r.txdata);
            vsp_pkg::HA_RXDATA: s_nxt.prdata = 32'(s_r.rxdata);
            vsp_pkg::HA_STATUS: s_nxt.prdata = 32'({s_r.frames, 7'h00, s_r.rx_done});
            default:            s_nxt.prdata = '0;
         endcase
      end
      if (psel_i && penable_i && pwrite_i) begin
         unique case (paddr_i)
            vsp_pkg::HA_CTRL:   s_nxt.ctrl   = pwdata_i[7:0];
            vsp_pkg::HA_FRAME:  s_nxt.frame  = pwdata_i[9:0];
            vsp_pkg::HA_TXPOS:  s_nxt.txpos  = pwdata_i[9:0];
            vsp_pkg::HA_RXPOS:  s_nxt.rxpos  = pwdata_i[9:0];
            vsp_pkg::HA_TXDATA: s_nxt.txdata = pwdata_i[15:0];
            vsp_pkg::HA_STATUS: begin
               if (pwdata_i[vsp_pkg::ST_DONE_BIT]) begin
                  s_nxt.rx_done = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      if (!en) begin
         s_nxt.hc     = '0;
         s_nxt.bclk   = 1'b0;
         s_nxt.fs     = 1'b0;
         s_nxt.ds_oe  = 1'b0;
         s_nxt.strobe = 1'b0;
         s_nxt.tx_cnt = '0;
         s_nxt.rx_cnt = '0;
         s_nxt.pulses = '0;
         s_nxt.ccyc   = 11'(clen - 11'h001);
      end else if (s_r.hc != vsp_pkg::BCLK_HALF_CYC - 4'h1) begin
         s_nxt.hc = s_r.hc + 4'h1;
      end else begin
         s_nxt.hc   = '0;
         s_nxt.bclk = ~s_r.bclk;
         if (!s_r.bclk) begin
            // device data is sampled late, at the rising edge that ends the bit,
            // to leave room for both synchronisers
            if (!dbl || s_r.ccyc[0]) begin
               bp = dbl ? s_r.ccyc[10:1] : s_r.ccyc[9:0];
               if (strobed) begin
                  if (txs_f) begin
                     s_nxt.rx_sh  = {s_r.rx_sh[14:0], us_f};
                     s_nxt.rx_cnt = s_r.rx_cnt + 5'h01;
                     if (s_nxt.rx_cnt == vsp_pkg::SAMPLE_CNT) begin
                        s_nxt.rxdata = s_nxt.rx_sh;
                        s_nxt.rx_cnt = '0;
                        set_done     = 1'b1;
                     end
                  end
               end else begin
                  if (bp == s_r.rxpos) begin
                     s_nxt.rx_cnt = vsp_pkg::SAMPLE_CNT;
                  end
                  if (s_nxt.rx_cnt != '0) begin
                     s_nxt.rx_sh  = {s_r.rx_sh[14:0], us_f};
                     s_nxt.rx_cnt = s_nxt.rx_cnt - 5'h01;
                     if (s_nxt.rx_cnt == '0) begin
                        s_nxt.rxdata = s_nxt.rx_sh;
                        set_done     = 1'b1;
                     end
                  end
               end
            end
            s_nxt.ccyc = (11'(s_r.ccyc + 11'h001) == clen) ? '0 : 11'(s_r.ccyc + 11'h001);
            s_nxt.fs   = (s_nxt.ccyc == '0);
            if (s_nxt.fs) begin
               s_nxt.frames = s_r.frames + 8'h01;
            end
            if (!dbl || !s_nxt.ccyc[0]) begin
               bp = dbl ? s_nxt.ccyc[10:1] : s_nxt.ccyc[9:0];
               if (bp == s_r.txpos) begin
                  s_nxt.tx_sh  = s_r.txdata;
                  s_nxt.tx_cnt = vsp_pkg::SAMPLE_CNT;
                  s_nxt.pulses = strobed ? 5'(s_r.ctrl[vsp_pkg::HC_PULSES_LSB +: vsp_pkg::IDX_W])
                                           + 5'h01 : 5'h01;
               end
               if (s_nxt.tx_cnt != '0) begin
                  s_nxt.ds_o   = strobed & s_nxt.tx_sh[15];
                  s_nxt.ds_oe  = strobed | ~s_nxt.tx_sh[15];
                  s_nxt.strobe = strobed;
                  s_nxt.tx_sh  = {s_nxt.tx_sh[14:0], 1'b0};
                  s_nxt.tx_cnt = s_nxt.tx_cnt - 5'h01;
                  if (s_nxt.tx_cnt == '0) begin
                     s_nxt.pulses = s_nxt.pulses - 5'h01;
                  end
               end else begin
                  // one idle bit between pulses gives the device a clean edge
                  s_nxt.ds_oe  = 1'b0;
                  s_nxt.strobe = 1'b0;
                  if (s_nxt.pulses != '0) begin
                     s_nxt.tx_sh  = s_r.txdata;
                     s_nxt.tx_cnt = vsp_pkg::SAMPLE_CNT;
                  end
               end
            end
         end
      end
      if (set_done) begin
         s_nxt.rx_done = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata_o          = s_r.prdata;
   assign pready_o          = s_r.pready;
   assign pslverr_o         = 1'b0 & s_r.pready;
   assign link.frame_sync   = s_r.fs;
   assign link.bit_clock_in = s_r.bclk;
   assign link.rx_strobe    = s_r.strobe;
   assign link.host_ds_o    = s_r.ds_o;
   assign link.host_ds_oe   = s_r.ds_oe;
endmodule // vsp_host
`default_nettype wire

// File: vsp_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module vsp_link_checker (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // link signals
   input wire logic frame_sync,
   input wire logic bit_clock_in,
   input wire logic rx_strobe,
   input wire logic tx_strobe,
   input wire logic dev_ds_o,
   input wire logic dev_ds_oe,
   input wire logic dev_us_o,
   input wire logic dev_us_oe
);
   logic [9:0] tx_cnt_r;
   logic [9:0] rx_cnt_r;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // strobe lengths in mclk cycles, 20 per bit clock
   always_ff @(posedge mclk_i) begin
      tx_cnt_r <= tx_strobe ? tx_cnt_r + 10'h001 : 10'h000;
      rx_cnt_r <= rx_strobe ? rx_cnt_r + 10'h001 : 10'h000;
   end
   strobe_drive_a: assert property (tx_strobe |-> dev_us_oe)
      else $error("upstream not driven under strobe");
   strobe_release_a: assert property ($fell(tx_strobe) |-> !dev_us_oe)
      else $error("upstream still driven after strobe");
   strobe_len_a: assert property ($fell(tx_strobe) |-> tx_cnt_r inside {[319:321]})
      else $error("transmit strobe length wrong");
   rx_len_a: assert property ($fell(rx_strobe) |-> rx_cnt_r inside {[319:321]})
      else $error("receive strobe length wrong");
   strobe_edge_a: assert property (($rose(tx_strobe) || $fell(tx_strobe)) |-> bit_clock_in)
      else $error("strobe moved off rising edge");
   us_launch_a: assert property (($changed(dev_us_o) || $changed(dev_us_oe)) |-> bit_clock_in)
      else $error("upstream moved off rising edge");
   ds_launch_a: assert property (($changed(dev_ds_o) || $changed(dev_ds_oe)) |-> bit_clock_in)
      else $error("downstream moved off rising edge");
   ds_open_a: assert property (dev_ds_oe |-> !dev_ds_o && !tx_strobe)
      else $error("downstream drive in wrong mode");
   sync_quiet_a: assert property ($rose(frame_sync) |-> !rx_strobe)
      else $error("receive strobe high at frame start");
   fs_width_a: assert property ($rose(frame_sync) |-> frame_sync[*8] ##[1:16] !frame_sync)
      else $error("frame sync width wrong");
   cover property ($fell(tx_strobe));
   cover property ($fell(rx_strobe));
   cover property ($fell(dev_ds_oe));
endmodule // vsp_link_checker
`default_nettype wire

// File: tb_voice_serial_data_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_voice_serial_data_port;
   logic             mclk_i = 1'b0;
   logic             reset_n_i = 1'b0;
   logic [15:0]      frm_cfg = 16'h0000;
   logic [15:0]      ch1_cfg = 16'h0000;
   logic [15:0]      ch2_cfg = 16'h0000;
   logic [1:0][15:0] tx_smp = '0;
   logic [1:0][15:0] rx_smp;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0000_0000;
   logic [31:0]      prdata;
   logic [31:0]      rd;
   logic             pready;
   logic [1:0]       rx_vld;
   logic             frm_st;
   int               vld_n = 0;
   int               fst_n = 0;
   integer           seed = 32'hbde4_b95d;
   int               miscompares = 0;
   int               checked = 0;
   int               cyc = 0;
   int               s;
   vsp_link_if lnk ();
   always #(vsp_pkg::MCLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
   vsp_device vsp_device_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .link(lnk),
      .serial_frame_config_i(frm_cfg), .serial_channel1_config_i(ch1_cfg),
      .serial_channel2_config_i(ch2_cfg), .tx_sample_i(tx_smp), .rx_sample_o(rx_smp),
      .rx_valid_o(rx_vld), .frame_start_o(frm_st));
   vsp_host vsp_host_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(), .link(lnk));
   vsp_link_checker vsp_link_checker_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
      .frame_sync(lnk.frame_sync), .bit_clock_in(lnk.bit_clock_in),
      .rx_strobe(lnk.rx_strobe), .tx_strobe(lnk.tx_strobe), .dev_ds_o(lnk.dev_ds_o),
      .dev_ds_oe(lnk.dev_ds_oe), .dev_us_o(lnk.dev_us_o), .dev_us_oe(lnk.dev_us_oe));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'(d);
      @(posedge mclk_i);
      penable <= 1'b1;
      @(posedge mclk_i);
      while (pready !== 1'b1) @(posedge mclk_i);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one exchange: reset, configure both ends, let three frames pass, compare
   task automatic run(input int c, input logic dbl, input logic strb, input logic lin,
                      input logic dir, input int sl, input int p, input int n);
      logic [15:0] ht;
      logic [15:0] cfg;
      int          f;
      ht = 16'($random(seed));
      cfg = {4'(n - 1), 2'b00, 6'(sl), 1'($random(seed)), lin, dir, 1'b1};
      tx_smp <= {16'($random(seed)), 16'($random(seed))};
      reset_n_i <= 1'b0;
      frm_cfg <= {2'b00, 6'h06, 5'h00, strb, dbl, 1'b1};
      ch1_cfg <= (c == 0) ? cfg : 16'h0000;
      ch2_cfg <= (c == 1) ? cfg : 16'h0000;
      repeat (10) @(posedge mclk_i);
      vld_n = 0;
      fst_n = 0;
      reset_n_i <= 1'b1;
      @(posedge mclk_i);
      apb(1'b1, vsp_pkg::HA_FRAME, strb ? 80 : 48);
      apb(1'b1, vsp_pkg::HA_TXPOS, strb ? 2 : sl * 8);
      apb(1'b1, vsp_pkg::HA_RXPOS, sl * 8);
      apb(1'b1, vsp_pkg::HA_TXDATA, ht);
      apb(1'b1, vsp_pkg::HA_CTRL, {4'(p - 1), 1'b0, dbl, strb, 1'b1});
      f = 0;
      // first frame only aligns, so wait for steady data
      while (f < 3) begin
         apb(1'b0, vsp_pkg::HA_STATUS, 0);
         f = rd[15:8];
      end
      apb(1'b0, vsp_pkg::HA_RXDATA, 0);
      chk(16'(vld_n != 0), 16'(!strb || n <= p));
      chk(16'(fst_n > 1), 16'h0001);
      if (strb) begin
         chk(rd[15:0], tx_smp[0]);
         chk(rx_smp[0], (n <= p) ? ht : 16'h0000);
      end else if (dir) begin
         chk(rd[15:0], 16'hFFFF);
         chk(rx_smp[c], lin ? 16'hFFFF : 16'h00FF);
      end else begin
         chk(rd[15:0], lin ? tx_smp[c] : {tx_smp[c][7:0], 8'hFF});
         chk(rx_smp[c], lin ? ht : {8'h00, ht[15:8]});
      end
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (rx_vld != 2'b00) vld_n++;
      if (frm_st) fst_n++;
      if (cyc == 90000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      for (int i = 0; i < 6; i++) begin
         s = $unsigned($random(seed)) % 5;
         run(i % 2, i > 2, 1'b0, i % 3 != 0, i == 4, (i % 3 != 0) ? s & 6 : s, 1, 1);
      end
      for (int i = 1; i < 5; i++) run(0, 1'b0, 1'b1, 1'b1, 1'b0, 0, 3, i);
      apb(1'b0, 8'h1C, 0);
      chk(rd[15:0], 16'h0000);
      summarize();
   end
endmodule // tb_voice_serial_data_port
`default_nettype wire
